// ---- logic/pll_seq_pkg.sv ----
// Shared constants for the PLL power-up sequencer and its ratio decoder.
package pll_seq_pkg;

  // ************************************************************
  // Register map, word offsets on the plain register port.
  // ************************************************************
  localparam logic [3:0] OFS_PRESCALE  = 4'h0;
  localparam logic [3:0] OFS_OUTDIV    = 4'h1;
  localparam logic [3:0] OFS_FRAC_LO   = 4'h2;
  localparam logic [3:0] OFS_FRAC_MID  = 4'h3;
  localparam logic [3:0] OFS_FRAC_HI   = 4'h4;
  localparam logic [3:0] OFS_INT       = 4'h5;
  localparam logic [3:0] OFS_MODE      = 4'h6;
  localparam logic [3:0] OFS_CAL       = 4'h7;
  localparam logic [3:0] OFS_CTRL      = 4'h8;
  localparam logic [3:0] OFS_STATUS    = 4'h9;

  // ************************************************************
  // Field positions.
  // ************************************************************
  localparam int CTRL_START_BIT   = 0;
  localparam int CTRL_SRC_BIT     = 1;
  localparam int STAT_POWER_BIT   = 0;
  localparam int STAT_SETTLED_BIT = 1;
  localparam int STAT_REF_BIT     = 2;
  localparam int STAT_SRC_BIT     = 3;

  // ************************************************************
  // Reset values.
  // ************************************************************
  localparam logic [1:0] RST_PRESCALE = 2'h0;
  localparam logic [7:0] RST_OUTDIV   = 8'h10;
  localparam logic [7:0] RST_INT      = 8'h40;
  localparam logic [1:0] RST_MODE     = 2'h3;
  localparam logic [7:0] RST_CAL      = 8'h80;

  // ************************************************************
  // Codes of the prescaler and the mode multiplier field.
  // ************************************************************
  localparam logic [1:0] PRESCALE_DIV1 = 2'b00;
  localparam logic [1:0] PRESCALE_DIV2 = 2'b01;
  localparam logic [1:0] PRESCALE_DIV4 = 2'b10;
  localparam logic [1:0] PRESCALE_DIV8 = 2'b11;
  localparam logic [3:0] DIV_BY_1      = 4'h1;
  localparam logic [3:0] DIV_BY_2      = 4'h2;
  localparam logic [3:0] DIV_BY_4      = 4'h4;
  localparam logic [3:0] DIV_BY_8      = 4'h8;
  localparam logic [1:0] MODE_CORR_A   = 2'b01;
  localparam logic [1:0] MODE_BYPASS   = 2'b11;

  // ************************************************************
  // Timing.
  // ************************************************************
  localparam int CLK_PERIOD_NS   = 100;
  localparam int SETTLE_TIME_US  = 800;
  localparam int SETTLE_CYC_DFLT = (SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CNT_W    = 16;
  localparam int REF_IDLE_CYC    = 255;
  localparam int REF_IDLE_W      = 8;

  // Power sequencing states.
  typedef enum logic [1:0] {ST_OFF, ST_SETTLE, ST_RUN} pll_state_t;

endpackage

// ---- logic/pll_cfg_if.sv ----
// Carrier between the sequencer and its ratio decoder.
`timescale 1ns/10ps
`default_nettype none
interface pll_cfg_if;
  logic [1:0]  prescale;
  logic [1:0]  mode;
  logic [7:0]  int_factor;
  logic [23:0] frac_factor;
  logic [3:0]  ref_div;
  logic        corr_a_en;
  logic        corr_b_en;
  logic [31:0] mult_word;

  modport seq
  (
    output prescale, mode, int_factor, frac_factor,
    input  ref_div, corr_a_en, corr_b_en, mult_word
  );
  modport calc
  (
    input  prescale, mode, int_factor, frac_factor,
    output ref_div, corr_a_en, corr_b_en, mult_word
  );
endinterface
`default_nettype wire

// ---- logic/pll_ratio_decode.sv ----
// Decodes prescaler, mode and factor settings into loop control words.
`timescale 1ns/10ps
`default_nettype none
module pll_ratio_decode
  import pll_seq_pkg::*;
(
  pll_cfg_if.calc cfg
);

  // ************************************************************
  // Reference prescaler decode.
  // ************************************************************
  // Prescaler code to divide ratio; code 01 halves the reference.
  always_comb
  begin
    case (cfg.prescale)
      PRESCALE_DIV1: cfg.ref_div = DIV_BY_1;
      PRESCALE_DIV2: cfg.ref_div = DIV_BY_2;
      PRESCALE_DIV4: cfg.ref_div = DIV_BY_4;
      default:       cfg.ref_div = DIV_BY_8;
    endcase
  end

  // ************************************************************
  // Correction factors and loop multiplier.
  // ************************************************************
  // Code 11 turns both corrections off so the factors alone set the ratio.
  always_comb
  begin
    cfg.corr_a_en = (cfg.mode == MODE_CORR_A);
    cfg.corr_b_en = (cfg.mode != MODE_CORR_A) && (cfg.mode != MODE_BYPASS);
  end

  // Integer part in the top byte, fraction as a 24-bit binary fraction.
  assign cfg.mult_word = {cfg.int_factor, cfg.frac_factor};

endmodule
`default_nettype wire

// ---- logic/pll_powerup_sequencer.sv ----
// Register file, power sequencing and clock selection for the fractional-N PLL.
// Functional notes
// - Prescaler codes 00, 10, 11 divide the reference by 1, 4, 8.
// - Mode code 11 bypasses both correction factors.
// - Loop output is prescaled reference times integer plus fractional factor.
// - Internal master clock is loop output divided by the output divider code.
// - The loop reference comes from the shared reference clock pin.
// - Clearing start powers the loop down; nothing else is needed.
// - Source select zero bypasses the loop, which may then be powered down.
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module pll_powerup_sequencer
  import pll_seq_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC_DFLT
)
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        shared_reference_clock_pin,
  output logic             pll_ref_clk,
  output logic             pll_power_en,
  output logic      [3:0]  pll_ref_div,
  output logic      [31:0] pll_mult_word,
  output logic             pll_corr_a_en,
  output logic             pll_corr_b_en,
  output logic      [7:0]  pll_cal_ratio,
  output logic      [7:0]  loop_output_divider,
  output logic             master_clock_source_select,
  output logic             pll_settled
);

  // ************************************************************
  // Configuration registers.
  // ************************************************************
  logic [1:0]  prescale_reg;
  logic [7:0]  outdiv_reg;
  logic [23:0] frac_reg;
  logic [7:0]  int_reg;
  logic [1:0]  mode_reg;
  logic [7:0]  cal_reg;
  logic        start_reg;
  logic        src_sel_reg;
  logic        ref_s1_reg;
  logic        ref_s2_reg;
  logic        ref_s3_reg;
  logic        ref_active_reg;
  logic [REF_IDLE_W-1:0]   ref_idle_reg;
  logic [SETTLE_CNT_W-1:0] settle_cnt_reg;
  pll_state_t  state_reg;
  pll_state_t  state_next;
  logic        stop_req;

  pll_cfg_if cfg ();

  // Register writes; the fraction is split over three byte addresses.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prescale_reg <= RST_PRESCALE;
      outdiv_reg   <= RST_OUTDIV;
      frac_reg     <= 24'h00_0000;
      int_reg      <= RST_INT;
      mode_reg     <= RST_MODE;
      cal_reg      <= RST_CAL;
      start_reg    <= 1'b0;
      src_sel_reg  <= 1'b0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        OFS_PRESCALE: prescale_reg <= reg_wdata[1:0];
        OFS_OUTDIV:   outdiv_reg <= reg_wdata;
        OFS_FRAC_LO:  frac_reg[7:0] <= reg_wdata;
        OFS_FRAC_MID: frac_reg[15:8] <= reg_wdata;
        OFS_FRAC_HI:  frac_reg[23:16] <= reg_wdata;
        OFS_INT:      int_reg <= reg_wdata;
        OFS_MODE:     mode_reg <= reg_wdata[1:0];
        OFS_CAL:      cal_reg <= reg_wdata;
        OFS_CTRL:
        begin
          start_reg   <= reg_wdata[CTRL_START_BIT];
          src_sel_reg <= reg_wdata[CTRL_SRC_BIT];
        end
        default:      start_reg <= start_reg;
      endcase
    end
  end

  // Read data stands for exactly one cycle; unmapped offsets read zero.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (!reg_rd)
      reg_rdata <= 8'h00;
    else
    begin
      case (reg_addr)
        OFS_PRESCALE: reg_rdata <= {6'h00, prescale_reg};
        OFS_OUTDIV:   reg_rdata <= outdiv_reg;
        OFS_FRAC_LO:  reg_rdata <= frac_reg[7:0];
        OFS_FRAC_MID: reg_rdata <= frac_reg[15:8];
        OFS_FRAC_HI:  reg_rdata <= frac_reg[23:16];
        OFS_INT:      reg_rdata <= int_reg;
        OFS_MODE:     reg_rdata <= {6'h00, mode_reg};
        OFS_CAL:      reg_rdata <= cal_reg;
        OFS_CTRL:     reg_rdata <= {6'h00, src_sel_reg, start_reg};
        OFS_STATUS:   reg_rdata <= {4'h0, src_sel_reg, ref_active_reg,
                                    (state_reg == ST_RUN), (state_reg != ST_OFF)};
        default:      reg_rdata <= 8'h00;
      endcase
    end
  end

  // ************************************************************
  // Reference pin conditioning.
  // ************************************************************
  // Two stages before any logic looks at the pin, a third for edge finding.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ref_s1_reg <= 1'b0;
      ref_s2_reg <= 1'b0;
      ref_s3_reg <= 1'b0;
    end
    else
    begin
      ref_s1_reg <= shared_reference_clock_pin;
      ref_s2_reg <= ref_s1_reg;
      ref_s3_reg <= ref_s2_reg;
    end
  end

  // Activity watch: only a slow reference can be seen here, so the
  // status bit is a hint for bring-up, not a frequency check.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ref_idle_reg   <= '0;
      ref_active_reg <= 1'b0;
    end
    else if (ref_s2_reg != ref_s3_reg)
    begin
      ref_idle_reg   <= '0;
      ref_active_reg <= 1'b1;
    end
    else if (ref_idle_reg == REF_IDLE_W'(REF_IDLE_CYC))
      ref_active_reg <= 1'b0;
    else
      ref_idle_reg <= ref_idle_reg + 1'b1;
  end

  // ************************************************************
  // Power sequencing.
  // ************************************************************
  assign stop_req = !start_reg;

  // Dropping start wins from any state and needs no other step.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF:    if (start_reg) state_next = ST_SETTLE;
      ST_SETTLE:
      begin
        if (stop_req)
          state_next = ST_OFF;
        else if (settle_cnt_reg >= SETTLE_CNT_W'(SETTLE_CYCLES - 1))
          state_next = ST_RUN;
      end
      ST_RUN:    if (stop_req) state_next = ST_OFF;
      default:   state_next = ST_OFF;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      state_reg <= ST_OFF;
    else
      state_reg <= state_next;
  end

  // Settling counter, runs only in ST_SETTLE; software sees the settled status bit, never the count.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      settle_cnt_reg <= '0;
    else if (state_reg != ST_SETTLE)
      settle_cnt_reg <= '0;
    else
      settle_cnt_reg <= settle_cnt_reg + 1'b1;
  end

  // ************************************************************
  // Loop control outputs.
  // ************************************************************
  assign cfg.prescale    = prescale_reg;
  assign cfg.mode        = mode_reg;
  assign cfg.int_factor  = int_reg;
  assign cfg.frac_factor = frac_reg;

  pll_ratio_decode u_decode
  (
    .cfg (cfg)
  );

  // All loop controls leave through flip-flops so the analog side sees clean levels.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pll_ref_clk                <= 1'b0;
      pll_power_en               <= 1'b0;
      pll_ref_div                <= DIV_BY_1;
      pll_mult_word              <= 32'h0000_0000;
      pll_corr_a_en              <= 1'b0;
      pll_corr_b_en              <= 1'b0;
      pll_cal_ratio              <= RST_CAL;
      loop_output_divider        <= RST_OUTDIV;
      master_clock_source_select <= 1'b0;
      pll_settled                <= 1'b0;
    end
    else
    begin
      pll_ref_clk                <= ref_s2_reg;
      pll_power_en               <= (state_next != ST_OFF);
      pll_ref_div                <= cfg.ref_div;
      pll_mult_word              <= cfg.mult_word;
      pll_corr_a_en              <= cfg.corr_a_en;
      pll_corr_b_en              <= cfg.corr_b_en;
      pll_cal_ratio              <= cal_reg;
      loop_output_divider        <= outdiv_reg;
      master_clock_source_select <= src_sel_reg;
      pll_settled                <= (state_next == ST_RUN);
    end
  end

  // ************************************************************
  // Checks.
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // A write that clears start, and the outputs it must quieten.
  sequence s_stop_write;
    reg_wr && (reg_addr == OFS_CTRL) && !reg_wdata[CTRL_START_BIT];
  endsequence

  // The state and the outputs both drop one edge after the write, as the outputs follow state_next;
  // the check samples one edge later still, so a restart right after is legal.
  sequence s_powered_off;
    ##1 (!pll_power_en && !pll_settled);
  endsequence

  a_prescale_four: assert property (
    $past(prescale_reg) == PRESCALE_DIV4 |-> pll_ref_div == DIV_BY_4)
    else $error("prescale code 10 did not give divide by 4");
  a_prescale_eight: assert property (
    prescale_reg == PRESCALE_DIV8 |=> pll_ref_div == DIV_BY_8)
    else $error("prescale code 11 did not give divide by 8");
  a_mode_bypass: assert property (
    mode_reg == MODE_BYPASS |=> !pll_corr_a_en && !pll_corr_b_en)
    else $error("bypass mode left a correction factor on");
  // At most one correction factor may act on the loop at a time.
  a_corr_exclusive: assert property (!(pll_corr_a_en && pll_corr_b_en))
    else $error("both correction factors were on at once");
  // The word leaves reset at zero, not at the integer default, so the
  // first edge after release is left out by the sampled reset level.
  a_mult_word: assert property (
    $past(nrst) |-> pll_mult_word == {$past(int_reg), $past(frac_reg)})
    else $error("loop multiplier does not match integer and fraction");
  a_mclk_divide: assert property (
    reg_wr && reg_addr == OFS_OUTDIV |-> ##2 loop_output_divider == $past(reg_wdata, 2))
    else $error("output divider not applied two cycles after write");
  a_ref_follow: assert property (pll_ref_clk == $past(ref_s2_reg))
    else $error("loop reference does not follow the shared pin");
  a_stop_power: assert property (s_stop_write |=> s_powered_off)
    else $error("clearing start did not power the loop down");
  // A start bit that has just been taken powers the loop on the next edge.
  a_start_power: assert property ($rose(start_reg) |=> pll_power_en)
    else $error("setting start did not power the loop up");
  a_bypass_select: assert property (
    reg_wr && reg_addr == OFS_CTRL && !reg_wdata[CTRL_SRC_BIT] |-> ##2 !master_clock_source_select)
    else $error("source select zero did not bypass the loop");
  // Settled may only rise once the counter has covered the whole wait.
  a_settle_wait: assert property (
    $rose(pll_settled) |-> $past(settle_cnt_reg) == SETTLE_CNT_W'(SETTLE_CYCLES - 1))
    else $error("loop reported settled before the settling wait");

endmodule
`default_nettype wire

// ---- tb/test_pll_powerup_sequencer.sv ----
// Self-checking testbench for the PLL power-up sequencer.
`timescale 1ns/10ps
`default_nettype none
module test_pll_powerup_sequencer;
  import pll_seq_pkg::*;

  // ************************************************************
  // Signals and instance.
  // ************************************************************
  localparam int SETTLE = 20;
  logic        core_clk;
  logic        nrst;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        shared_reference_clock_pin;
  logic        pll_ref_clk;
  logic        pll_power_en;
  logic [3:0]  pll_ref_div;
  logic [31:0] pll_mult_word;
  logic        pll_corr_a_en;
  logic        pll_corr_b_en;
  logic [7:0]  pll_cal_ratio;
  logic [7:0]  loop_output_divider;
  logic        master_clock_source_select;
  logic        pll_settled;
  logic        rd_seen;
  logic [7:0]  exp_q[$];
  logic [7:0]  rst_tab[16];
  logic [7:0]  fb[3];
  int          bad_count;
  int          cmp_count;

  pll_powerup_sequencer #(.SETTLE_CYCLES(SETTLE)) pll_powerup_sequencer_i
  (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .shared_reference_clock_pin(shared_reference_clock_pin), .pll_ref_clk(pll_ref_clk),
    .pll_power_en(pll_power_en), .pll_ref_div(pll_ref_div), .pll_mult_word(pll_mult_word),
    .pll_corr_a_en(pll_corr_a_en), .pll_corr_b_en(pll_corr_b_en),
    .pll_cal_ratio(pll_cal_ratio), .loop_output_divider(loop_output_divider),
    .master_clock_source_select(master_clock_source_select), .pll_settled(pll_settled)
  );

  // The 100 ns clock.
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ************************************************************
  // Helpers.
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // A write is one strobe cycle; the task returns at the edge that takes it.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // The expected byte is queued; the monitor below compares it.
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    exp_q.push_back(e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask

  // Lets n edges pass and stops mid-cycle, where outputs are settled.
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // Read data stand only in the cycle after the strobe, so look there.
  always @(posedge core_clk) rd_seen <= reg_rd;
  always @(negedge core_clk)
  begin
    if (rd_seen === 1'b1)
      chk("reg_rdata", {24'h0000_00, exp_q.pop_front()}, {24'h0000_00, reg_rdata});
  end

  // A hang is cut short here and counted as a mismatch.
  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    finish_test();
  end

  // ************************************************************
  // Main sequence.
  // ************************************************************
  initial
  begin
    nrst = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    shared_reference_clock_pin = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    void'($urandom(32'h9b09_1bde));
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    // Reset values, the read-only status and unmapped offsets.
    rst_tab = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h40, 8'h03, 8'h80,
                8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    wr(OFS_STATUS, 8'hff);
    wr(4'hb, 8'h5a);
    for (int i = 0; i < 16; i++) rd(i[3:0], rst_tab[i]);
    step(1);
    chk("mult_rst", 32'h4000_0000, pll_mult_word);
    $display("test reset done");
    // Every prescaler code, each followed by the mode code of the same value.
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_PRESCALE, i[7:0]);
      step(1);
      chk("ref_div", {28'h000_0000, DIV_BY_1 << i}, {28'h000_0000, pll_ref_div});
      wr(OFS_MODE, i[7:0]);
      step(1);
      chk("corr_a", (i == 1), pll_corr_a_en);
      chk("corr_b", (i == 0 || i == 2), pll_corr_b_en);
    end
    $display("test codes done");
    // Random fraction and integer reach the multiplier word byte by byte.
    for (int k = 0; k < 4; k++)
    begin
      foreach (fb[j]) fb[j] = 8'($urandom);
      wr(OFS_FRAC_LO, fb[0]);
      wr(OFS_FRAC_MID, fb[1]);
      wr(OFS_FRAC_HI, fb[2]);
      wr(OFS_INT, fb[0] ^ fb[2]);
      step(1);
      chk("mult_word", {fb[0] ^ fb[2], fb[2], fb[1], fb[0]}, pll_mult_word);
      rd(OFS_FRAC_MID, fb[1]);
    end
    // Full ordered power-up with prescale code 11, integer-only ratio.
    wr(OFS_PRESCALE, 8'h03);
    wr(OFS_OUTDIV, 8'h10);
    wr(OFS_FRAC_LO, 8'h00);
    wr(OFS_FRAC_MID, 8'h00);
    wr(OFS_FRAC_HI, 8'h00);
    wr(OFS_INT, 8'h50);
    wr(OFS_MODE, 8'h03);
    wr(OFS_CAL, 8'h60);
    step(1);
    chk("mult_int", 32'h5000_0000, pll_mult_word);
    chk("cal", 32'h0000_0060, {24'h0000_00, pll_cal_ratio});
    chk("ref_div8", 32'h0000_0008, {28'h000_0000, pll_ref_div});
    chk("outdiv16", 32'h0000_0010, {24'h0000_00, loop_output_divider});
    wr(OFS_CTRL, 8'h01);
    step(1);
    chk("power_on", 1, pll_power_en);
    chk("early", 0, pll_settled);
    step(SETTLE - 1);
    chk("not_yet", 0, pll_settled);
    step(1);
    chk("settled", 1, pll_settled);
    rd(OFS_STATUS, 8'h03);
    wr(OFS_OUTDIV, 8'h08);
    step(1);
    chk("outdiv8", 32'h0000_0008, {24'h0000_00, loop_output_divider});
    wr(OFS_CTRL, 8'h03);
    step(1);
    chk("src_sel", 1, master_clock_source_select);
    $display("test power up done");
    // Clearing start alone powers down; the source select stays put.
    wr(OFS_CTRL, 8'h02);
    step(1);
    chk("power_off", 0, pll_power_en);
    chk("unsettled", 0, pll_settled);
    chk("src_kept", 1, master_clock_source_select);
    wr(OFS_CTRL, 8'h00);
    step(1);
    chk("bypass", 0, master_clock_source_select);
    $display("test power down done");
    // The pin reaches the loop three edges later and marks the reference active.
    @(posedge core_clk);
    shared_reference_clock_pin <= 1'b1;
    step(2);
    chk("ref_lag", 0, pll_ref_clk);
    step(1);
    chk("ref_rise", 1, pll_ref_clk);
    rd(OFS_STATUS, 8'h04);
    @(posedge core_clk);
    shared_reference_clock_pin <= 1'b0;
    step(3);
    chk("ref_fall", 0, pll_ref_clk);
    step(2);
    $display("test reference done");
    finish_test();
  end
endmodule
`default_nettype wire
